// File: inc/irq_vec_pkg.sv
// package for the interrupt arbitration and vectoring block
// assumes a single 50 MHz system clock
`default_nettype none
package irq_vec_pkg;
  localparam int unsigned NUM_SRC = 17;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned VEC_W = 16;
  localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
  localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
  localparam logic [VEC_W-1:0] VEC_STEP = 16'h0008;
  localparam logic [VEC_W-1:0] VEC_LAST = 16'h0083;
  // fixed order indices
  localparam logic [IDX_W-1:0] SRC_EXT0 = 5'h00;
  localparam logic [IDX_W-1:0] SRC_TIMER0 = 5'h01;
  localparam logic [IDX_W-1:0] SRC_EXT1 = 5'h02;
  localparam logic [IDX_W-1:0] SRC_TIMER1 = 5'h03;
  localparam int unsigned SRC_SERIAL0 = 4;
  localparam int unsigned SRC_TIMER2 = 5;
  localparam int unsigned SRC_SPI = 6;
  localparam int unsigned SRC_SMBUS = 7;
  localparam int unsigned SRC_USB = 8;
  localparam int unsigned SRC_ADC_WIN = 9;
  localparam int unsigned SRC_ADC_DONE = 10;
  localparam int unsigned SRC_PCA = 11;
  localparam int unsigned SRC_CMP0 = 12;
  localparam int unsigned SRC_CMP1 = 13;
  localparam int unsigned SRC_TIMER3 = 14;
  localparam int unsigned SRC_VBUS = 15;
  localparam int unsigned SRC_SERIAL1 = 16;
  // comparator control flag positions
  localparam int unsigned CMP_FALL_BIT = 4;
  localparam int unsigned CMP_RISE_BIT = 5;
  // latency figures in system clocks
  localparam int unsigned DETECT_CLKS = 1;
  localparam int unsigned CALL_CLKS = 5;
  localparam int unsigned MIN_RESPONSE_CLKS = 6;
  localparam int unsigned RETURN_FROM_IRQ_CLKS = 6;
  localparam int unsigned DIV_CLKS = 8;
  localparam int unsigned MAX_RESPONSE_CLKS = 20;
  localparam logic [2:0] CALL_LAST = 3'(CALL_CLKS - 1);
  localparam logic [16:0] SRC_ENABLE_RESET = 17'h00000;
  localparam logic [16:0] SRC_PRIO_RESET = 17'h00000;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_CALL,
    ST_HOLD
  } seq_state_e;

  typedef struct packed {
    logic instr_done;   // current instruction completes this cycle
    logic return_from_irq_done;    // completing instruction is a return
    logic stall;        // flash write/erase or usb fifo access
  } cpu_status_s;

  typedef struct packed {
    seq_state_e state;
    logic [2:0] call_cnt;
    logic [IDX_W-1:0] sel_idx;
    logic sel_high;
    logic hold_one;          // one instruction must run after a return
    logic [1:0] active;      // bit0 low isr running, bit1 high isr running
    logic req;
    logic [VEC_W-1:0] vector;
    logic call_go;
    logic call_done;
    logic [3:0] hw_clear;    // ext0, timer0, ext1, timer1
  } irq_state_s;
endpackage
`default_nettype wire

// File: design/irq_vectoring.sv
// interrupt arbitration, vectoring and response timing
// assumes flags synchronous to core_clk_i and a cpu sequencer that
// reports instruction completion and stalls each cycle
// ---------------------------------------------------------------
// What this block does
// - sample and decode pending requests every clock
// - fastest response: one detect, five call clocks
// - one instruction runs after return before call
// - worst case twenty clocks: return then divide
// - equal or higher running routine blocks request
// - cpu stall defers vectoring, adds its length
// - reset vector zero; sources 0x0003 step eight
// - ties broken by lowest fixed index first
// - only ext0/1, timer0/1 flags cleared on vectoring
// - enable bits gate sources; priority bits set level
// - spi requested by any of four flags
// - comparator requested by fall or rise flag
// - timer3 requested by high or low overflow
// - serial1 requested by receive or transmit flag
// - global enable gates all maskable requests
// - high preempts low; high never preempted
// - flag still set after return re-enters routine
// ---------------------------------------------------------------
`default_nettype none
module irq_vectoring (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic global_irq_enable_i,
  input wire logic [6:0] enable_reg_first_i,
  input wire logic [7:0] enable_reg_second_i,
  input wire logic [1:0] enable_reg_third_i,
  input wire logic [6:0] priority_reg_first_i,
  input wire logic [7:0] priority_reg_second_i,
  input wire logic [1:0] priority_reg_third_i,
  input wire logic ext0_pending_i,
  input wire logic timer0_overflow_flag_i,
  input wire logic ext1_pending_i,
  input wire logic timer1_overflow_flag_i,
  input wire logic serial0_rx_flag_i,
  input wire logic serial0_tx_flag_i,
  input wire logic timer2_high_overflow_i,
  input wire logic timer2_low_overflow_i,
  input wire logic spi_done_flag_i,
  input wire logic spi_write_collision_i,
  input wire logic spi_mode_fault_i,
  input wire logic spi_rx_overrun_i,
  input wire logic smbus_flag_i,
  input wire logic usb_flag_i,
  input wire logic adc_window_flag_i,
  input wire logic adc_done_flag_i,
  input wire logic pca_module_flag_i,
  input wire logic [7:0] cmp0_control_i,
  input wire logic [7:0] cmp1_control_i,
  input wire logic timer3_high_overflow_i,
  input wire logic timer3_low_overflow_i,
  input wire logic vbus_level_flag_i,
  input wire logic serial1_rx_flag_i,
  input wire logic serial1_tx_flag_i,
  input wire irq_vec_pkg::cpu_status_s cpu_i,
  output logic irq_request_o,
  output logic [15:0] irq_vector_o,
  output logic call_start_o,
  output logic call_done_o,
  output logic [3:0] hw_flag_clear_o,
  output logic [1:0] isr_active_o
);

  // -------------------------------------------------------------
  // source gathering
  // -------------------------------------------------------------
  logic [16:0] flag;
  logic [16:0] enable;
  logic [16:0] prio;
  logic [16:0] req_hi;
  logic [16:0] req_lo;

  always_comb begin
    flag = {serial1_rx_flag_i | serial1_tx_flag_i,
            vbus_level_flag_i,
            timer3_high_overflow_i | timer3_low_overflow_i,
            cmp1_control_i[irq_vec_pkg::CMP_FALL_BIT]
              | cmp1_control_i[irq_vec_pkg::CMP_RISE_BIT],
            cmp0_control_i[irq_vec_pkg::CMP_FALL_BIT]
              | cmp0_control_i[irq_vec_pkg::CMP_RISE_BIT],
            pca_module_flag_i,
            adc_done_flag_i,
            adc_window_flag_i,
            usb_flag_i,
            smbus_flag_i,
            spi_done_flag_i | spi_write_collision_i
              | spi_mode_fault_i | spi_rx_overrun_i,
            timer2_high_overflow_i | timer2_low_overflow_i,
            serial0_rx_flag_i | serial0_tx_flag_i,
            timer1_overflow_flag_i,
            ext1_pending_i,
            timer0_overflow_flag_i,
            ext0_pending_i};
    enable = {enable_reg_third_i, enable_reg_second_i,
              enable_reg_first_i};
    prio = {priority_reg_third_i, priority_reg_second_i,
            priority_reg_first_i};
  end

  genvar gi;
  generate
    for (gi = 0; gi < irq_vec_pkg::NUM_SRC; gi++) begin : g_src
      assign req_hi[gi] = global_irq_enable_i & enable[gi] & flag[gi]
                          & prio[gi];
      assign req_lo[gi] = global_irq_enable_i & enable[gi] & flag[gi]
                          & ~prio[gi];
    end
  endgenerate

  // -------------------------------------------------------------
  // arbitration
  // -------------------------------------------------------------
  function automatic logic [4:0] first_set(input logic [16:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = irq_vec_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  logic win_any;
  logic win_high;
  logic [4:0] win_idx;

  always_comb begin
    win_high = |req_hi;
    win_any = win_high | (|req_lo);
    win_idx = win_high ? first_set(req_hi) : first_set(req_lo);
  end

  // -------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------
  irq_vec_pkg::irq_state_s s_q, s_d;
  logic allowed;

  always_comb begin
    s_d = s_q;
    s_d.call_go = 1'b0;
    s_d.call_done = 1'b0;
    s_d.hw_clear = 4'h0;
    // blocking by running routine of equal or higher level
    allowed = win_any && !s_q.active[1]
              && !(s_q.active[0] && !win_high);
    // request and selection refreshed every cycle except at call start; request held low during the call
    s_d.req = allowed;
    s_d.sel_idx = win_idx;
    s_d.sel_high = win_high;
    // vector holds the reset value until a request is allowed
    if (allowed) begin
      s_d.vector = irq_vec_pkg::VEC_BASE
                   + 16'({win_idx, 3'h0});
    end
    unique case (s_q.state)
      irq_vec_pkg::ST_RUN: begin
        if (cpu_i.instr_done && !cpu_i.stall) begin
          if (cpu_i.return_from_irq_done) begin
            // one more instruction before any call
            s_d.hold_one = 1'b1;
            if (s_q.active[1]) begin
              s_d.active[1] = 1'b0;
            end else begin
              s_d.active[0] = 1'b0;
            end
          end else begin
            // the one instruction after a return may end in the call
            s_d.hold_one = 1'b0;
            if (s_q.req) begin
            // detected last cycle, now start the call
            s_d.state = irq_vec_pkg::ST_CALL;
            s_d.call_cnt = 3'h0;
            s_d.call_go = 1'b1;
            s_d.req = 1'b0;
            s_d.sel_idx = s_q.sel_idx;
            s_d.sel_high = s_q.sel_high;
            s_d.vector = s_q.vector;
            if (s_q.sel_high) begin
              s_d.active[1] = 1'b1;
            end else begin
              s_d.active[0] = 1'b1;
            end
            // only the four oldest flags clear by hardware
            if (s_q.sel_idx <= irq_vec_pkg::SRC_TIMER1) begin
              s_d.hw_clear[s_q.sel_idx[1:0]] = 1'b1;
            end
            end
          end
        end
      end
      irq_vec_pkg::ST_CALL: begin
        s_d.req = 1'b0;
        s_d.vector = s_q.vector;
        if (!cpu_i.stall) begin
          s_d.call_cnt = s_q.call_cnt + 3'h1;
          if (s_q.call_cnt == irq_vec_pkg::CALL_LAST) begin
            s_d.state = irq_vec_pkg::ST_RUN;
            s_d.call_done = 1'b1;
          end
        end
      end
      default: begin
        s_d.state = irq_vec_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.state <= irq_vec_pkg::ST_RUN;
      s_q.vector <= irq_vec_pkg::RESET_VECTOR;
    end else begin
      s_q <= s_d;
    end
  end

  assign irq_request_o = s_q.req;
  assign irq_vector_o = s_q.vector;
  assign call_start_o = s_q.call_go;
  assign call_done_o = s_q.call_done;
  assign hw_flag_clear_o = s_q.hw_clear;
  assign isr_active_o = s_q.active;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  call_length_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    call_start_o && !cpu_i.stall ##1 !cpu_i.stall [*4] |=> call_done_o)
    else $error("call did not finish in five clocks");

  high_blocks_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    isr_active_o[1] |=> !irq_request_o)
    else $error("request raised during high routine");

  global_mask_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !global_irq_enable_i |=> !irq_request_o)
    else $error("request without global enable");

  vector_range_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    irq_request_o |-> (irq_vector_o[2:0] == 3'h3
      && irq_vector_o <= irq_vec_pkg::VEC_LAST))
    else $error("vector out of table");

  ext0_first_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (global_irq_enable_i && enable_reg_first_i[0] && ext0_pending_i
     && priority_reg_first_i[0] && !s_q.active[1]
     && s_q.state == irq_vec_pkg::ST_RUN && !s_q.req)
    |=> irq_vector_o == irq_vec_pkg::VEC_BASE)
    else $error("ext0 lost arbitration at high level");

  return_from_irq_hold_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (s_q.state == irq_vec_pkg::ST_RUN && cpu_i.instr_done
     && cpu_i.return_from_irq_done && !cpu_i.stall) |=> !call_start_o)
    else $error("call issued straight after return");

  stall_defer_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    cpu_i.stall && s_q.state == irq_vec_pkg::ST_RUN |=> !call_start_o)
    else $error("vectoring during stall");

  hw_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(call_start_o) |-> (hw_flag_clear_o == 4'h0)
      == (s_q.sel_idx > irq_vec_pkg::SRC_TIMER1))
    else $error("hardware clear on wrong source");

endmodule
`default_nettype wire

// File: verif/cpu_model.sv
// cpu sequencer model: completes an instruction every len_i clocks
// assumes the irq_vectoring call pulses on the same clock
`default_nettype none
module cpu_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] len_i,
  input wire logic return_from_irq_i,
  input wire logic stall_i,
  input wire logic call_start_i,
  input wire logic call_done_i,
  output var irq_vec_pkg::cpu_status_s cpu_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  logic in_call_q;
  logic run;
  // no instruction completes while calling or stalled
  assign run = !in_call_q && !call_start_i && !stall_i;
  always_comb begin
    cpu_o.instr_done = run && (cnt_q == len_i - 4'h1);
    cpu_o.return_from_irq_done = cpu_o.instr_done && return_from_irq_i;
    cpu_o.stall = stall_i;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
      in_call_q <= 1'b0;
    end else begin
      if (call_start_i) in_call_q <= 1'b1;
      else if (call_done_i) in_call_q <= 1'b0;
      if (call_start_i || cpu_o.instr_done) cnt_q <= 4'h0;
      else if (run) cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for irq_vectoring beside a cpu sequencer model
// assumes a 50 MHz core clock and the package constants
`default_nettype none
`define chk(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_errors++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SRC_OF [26] = '{0, 1, 2, 3, 4, 4, 5, 5, 6, 6, 6, 6, 7,
    8, 9, 10, 11, 12, 12, 13, 13, 14, 14, 15, 16, 16};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ea = 1'b0;
  logic [16:0] en = 17'h0;
  logic [16:0] pr = 17'h0;
  logic [25:0] flg = 26'h0;
  logic [3:0] len = 4'h1;
  logic return_from_irq = 1'b0;
  logic stall = 1'b0;
  irq_vec_pkg::cpu_status_s cpu;
  logic req, cs, cd;
  logic [15:0] vec;
  logic [3:0] hwc;
  logic [1:0] act;
  int n_errors = 0, checks_done = 0, cyc = 0, t_cs = 0, t_cd = 0;
  always #10 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    cyc++;
  end
  irq_vectoring dut (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .global_irq_enable_i(ea), .enable_reg_first_i(en[6:0]),
    .enable_reg_second_i(en[14:7]), .enable_reg_third_i(en[16:15]),
    .priority_reg_first_i(pr[6:0]), .priority_reg_second_i(pr[14:7]),
    .priority_reg_third_i(pr[16:15]), .ext0_pending_i(flg[0]),
    .timer0_overflow_flag_i(flg[1]), .ext1_pending_i(flg[2]),
    .timer1_overflow_flag_i(flg[3]), .serial0_rx_flag_i(flg[4]),
    .serial0_tx_flag_i(flg[5]), .timer2_high_overflow_i(flg[6]),
    .timer2_low_overflow_i(flg[7]), .spi_done_flag_i(flg[8]),
    .spi_write_collision_i(flg[9]), .spi_mode_fault_i(flg[10]),
    .spi_rx_overrun_i(flg[11]), .smbus_flag_i(flg[12]),
    .usb_flag_i(flg[13]), .adc_window_flag_i(flg[14]),
    .adc_done_flag_i(flg[15]), .pca_module_flag_i(flg[16]),
    .cmp0_control_i({2'h0, flg[18:17], 4'h0}),
    .cmp1_control_i({2'h0, flg[20:19], 4'h0}),
    .timer3_high_overflow_i(flg[21]), .timer3_low_overflow_i(flg[22]),
    .vbus_level_flag_i(flg[23]), .serial1_rx_flag_i(flg[24]),
    .serial1_tx_flag_i(flg[25]), .cpu_i(cpu), .irq_request_o(req),
    .irq_vector_o(vec), .call_start_o(cs), .call_done_o(cd),
    .hw_flag_clear_o(hwc), .isr_active_o(act));
  cpu_model cpu_far (.clk_i(core_clk), .rst_n_i(rst_n), .len_i(len),
    .return_from_irq_i(return_from_irq), .stall_i(stall), .call_start_i(cs),
    .call_done_i(cd), .cpu_o(cpu));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wt(input bit sel_done, input int lim);
    for (int i = 0; i < lim && !(sel_done ? cd : cs); i++)
      step(1);
    if (sel_done) t_cd = cyc;
    else t_cs = cyc;
  endtask
  task automatic do_return_from_irq();
    return_from_irq = 1'b1;
    for (int i = 0; i < 20 && !cpu.return_from_irq_done; i++) step(1);
    step(1);
    return_from_irq = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic one_src(input int k);
    int s, t_set;
    s = SRC_OF[k];
    step(2);
    en = 17'h1 << s;
    flg = 26'h1 << k;
    t_set = cyc;
    wt(0, 10);
    `chk("call_start", 1'b1, cs)
    `chk("detect", irq_vec_pkg::DETECT_CLKS + 1, t_cs - t_set)
    `chk("vector", 16'h3 + 16'(s) * 16'h8, vec)
    `chk("hw_clear", (s < 4) ? 4'(1 << s) : 4'h0, hwc)
    wt(1, 10);
    `chk("call_len", irq_vec_pkg::CALL_CLKS, t_cd - t_cs)
    flg = 26'h0;
    do_return_from_irq();
  endtask
  task automatic mask_prio();
    step(2);
    ea = 1'b0;
    en = 17'h1ffff;
    pr = 17'h10000;
    flg = 26'h2000008;
    step(8);
    `chk("masked_req", 1'b0, req)
    ea = 1'b1;
    wt(0, 10);
    `chk("prio_vector", irq_vec_pkg::VEC_LAST, vec)
    wt(1, 10);
    flg = 26'h0;
    do_return_from_irq();
  endtask
  task automatic nest();
    int n;
    len = 4'h3;
    step(4);
    flg = 26'h40;
    wt(0, 20);
    step(1);
    `chk("low_active", 2'b01, act)
    flg[2] = 1'b1;
    step(8);
    `chk("equal_blocked", 1'b0, req)
    flg[24] = 1'b1;
    wt(0, 20);
    `chk("preempt_vector", irq_vec_pkg::VEC_LAST, vec)
    step(1);
    `chk("both_active", 2'b11, act)
    flg[24] = 1'b0;
    flg[2] = 1'b0;
    step(8);
    do_return_from_irq();
    `chk("high_return", 2'b01, act)
    do_return_from_irq();
    n = 0;
    for (int i = 0; i < 40 && !cs; i++) begin
      @(negedge core_clk);
      if (cpu.instr_done) n++;
    end
    `chk("instr_between", 1, n)
    `chk("reenter_vector", 16'h002b, vec)
    wt(1, 20);
    flg = 26'h0;
    do_return_from_irq();
    len = 4'h1;
  endtask
  task automatic hi_tie();
    pr = 17'h00003;
    step(2);
    flg = 26'h3;
    wt(0, 10);
    `chk("hi_tie_vector", irq_vec_pkg::VEC_BASE, vec)
    `chk("hi_tie_clear", 4'h1, hwc)
    wt(1, 10);
    flg = 26'h0;
    do_return_from_irq();
    pr = 17'h0;
  endtask
  task automatic stall_call();
    pr = 17'h0;
    step(2);
    flg = 26'h6;
    wt(0, 10);
    `chk("tie_vector", 16'h000b, vec)
    `chk("tie_clear", 4'h2, hwc)
    step(1);
    stall = 1'b1;
    step(3);
    stall = 1'b0;
    wt(1, 20);
    `chk("stalled_call", irq_vec_pkg::CALL_CLKS + 3, t_cd - t_cs)
    flg = 26'h0;
    do_return_from_irq();
  endtask
  initial begin
    #80000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    step(1);
    `chk("reset_vector", irq_vec_pkg::RESET_VECTOR, vec)
    ea = 1'b1;
    for (int k = 0; k < 26; k++) one_src(k);
    mask_prio();
    nest();
    hi_tie();
    stall_call();
    tally_and_finish();
  end
endmodule
`default_nettype wire
